// ---- tb/clk_sources.sv ----
`timescale 1ns/1ps
module clk_sources (
  // Strap choice, changed by the bench only while reset is held.
  input  logic strap_fs_master,
  // Oscillators.
  output logic main_clk_in,
  output logic fs_clk_in_a,
  output logic crystal_44k_clk_in,
  // Straps.
  output logic fs_ratio_sel,
  output logic main_clk_rate_sel,
  output logic master_fs_source_sel
);
  // Low gives the crystal master straps; high gives fs-based master with a 384fs fs clock.
  assign fs_ratio_sel         = strap_fs_master;
  assign main_clk_rate_sel    = 1'b1;
  assign master_fs_source_sel = strap_fs_master;
  // Free-running oscillators at 24.576 MHz, 22.5792 MHz and 256 x 44.1 kHz.
  initial begin
    main_clk_in = 1'b0;
    forever #20.345 main_clk_in = ~main_clk_in;
  end
  initial begin
    crystal_44k_clk_in = 1'b0;
    forever #22.144 crystal_44k_clk_in = ~crystal_44k_clk_in;
  end
  initial begin
    fs_clk_in_a = 1'b0;
    forever #44.289 fs_clk_in_a = ~fs_clk_in_a;
  end
endmodule

// ---- tb/decoder_clock_sync_bitrate_control_chk.sv ----
`timescale 1ns/1ps
module decoder_clock_sync_bitrate_control_chk
  import clk_sync_pkg::*;
(
  // Clock and reset.
  input wire logic        aclk,
  input wire logic        aresetn,
  // Observed inputs.
  input wire logic        main_clk_in,
  input wire logic        stop_decoding,
  input wire frame_info_t frame_info,
  // Observed outputs.
  input wire logic        sck,
  input wire logic        main_clk_out,
  input wire logic        main_clk_out_oe_n,
  input wire logic        fs_clk_out_oe_n,
  input wire logic        audio_mute,
  input wire logic        master_req_active,
  input wire logic [3:0]  rate_index
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  AST_RST_OUT: assert property ($rose(aresetn) |-> audio_mute && fs_clk_out_oe_n &&
    !main_clk_out_oe_n && rate_index == RATE_IDX_DEFAULT) else $error("bad state after reset");
  AST_UNMUTE_CAUSE: assert property ($fell(audio_mute) |->
    $past(frame_info.sync_detect) || $past(frame_info.frame_verified)) else $error("unmute uncaused");
  AST_DIRECT_LOCK: assert property ($fell(audio_mute) && !$past(frame_info.frame_verified) |->
    $past(frame_info.crc_active) && !$past(frame_info.free_format)) else $error("lock too early");
  AST_FAIL_MUTED: assert property (audio_mute && frame_info.frame_failed &&
    !frame_info.sync_detect |=> audio_mute) else $error("unmuted after failure");
  AST_STOP_HALT: assert property (stop_decoding [*6] |-> audio_mute && !master_req_active)
    else $error("requests not halted by stop");
  AST_RATE_ON_LOCK: assert property (rate_index != $past(rate_index) |-> $fell(audio_mute))
    else $error("rate changed outside lock");
  AST_MAIN_COPY: assert property ((!main_clk_out_oe_n && $past(aresetn, 8) &&
    $stable(main_clk_in)) [*4] |-> main_clk_out == main_clk_in) else $error("main clock not copied");
  AST_SCK_HIGH: assert property ($rose(sck) |-> sck [*8])
    else $error("runt pulse on sck");

  cover property ($fell(audio_mute));
  cover property (stop_decoding [*6]);
  cover property ($fell(master_req_active));
endmodule

bind decoder_clock_sync_bitrate_control decoder_clock_sync_bitrate_control_chk chk_u (
  .aclk, .aresetn, .main_clk_in, .stop_decoding, .frame_info, .sck, .main_clk_out,
  .main_clk_out_oe_n, .fs_clk_out_oe_n, .audio_mute, .master_req_active, .rate_index);

// ---- tb/tb_decoder_clock_sync_bitrate_control.sv ----
`timescale 1ns/1ps
`define CHK(n, e, g) \
  begin \
    samples_checked++; \
    if ((g) !== (e)) begin \
      err_count++; \
      $display("unexpected %s exp %0h got %0h", n, e, g); \
    end \
  end
module tb_decoder_clock_sync_bitrate_control;
  import clk_sync_pkg::*;
  logic        aclk, aresetn, main_clk_in, fs_clk_in_a, crystal_44k_clk_in, stop_decoding;
  logic        fs_ratio_sel, main_clk_rate_sel, master_fs_source_sel, sck, ws, main_clk_out;
  logic        main_clk_out_oe_n, fs_clk_out, fs_clk_out_oe_n, audio_mute;
  logic        master_req_active, master_req_bit;
  logic [3:0]  rate_index;
  logic        strap_fs_master;
  axi_req_t    s_axi_req;
  axi_rsp_t    s_axi_rsp;
  frame_info_t frame_info;
  logic [31:0] v;
  int          c, f, err_count, samples_checked;
  int          need [4] = '{1, 2, 0, 1};

  clk_sources part_u (.strap_fs_master, .main_clk_in, .fs_clk_in_a, .crystal_44k_clk_in,
    .fs_ratio_sel,
    .main_clk_rate_sel, .master_fs_source_sel);
  decoder_clock_sync_bitrate_control dut_u (.aclk, .aresetn, .s_axi_req, .s_axi_rsp,
    .main_clk_in, .fs_clk_in_a, .crystal_44k_clk_in, .fs_ratio_sel, .main_clk_rate_sel,
    .master_fs_source_sel, .stop_decoding, .frame_info, .sck, .ws, .main_clk_out,
    .main_clk_out_oe_n, .fs_clk_out, .fs_clk_out_oe_n, .audio_mute, .master_req_active,
    .master_req_bit, .rate_index);

  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic guard(input int n);
    if (n >= 100) begin
      err_count++;
      end_of_test();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_req.awaddr  <= a;
    s_axi_req.awvalid <= 1'b1;
    s_axi_req.wdata   <= d;
    s_axi_req.wstrb   <= 4'hf;
    s_axi_req.wvalid  <= 1'b1;
    s_axi_req.bready  <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_rsp.awready) s_axi_req.awvalid <= 1'b0;
      if (s_axi_rsp.wready) s_axi_req.wvalid <= 1'b0;
    end while (s_axi_rsp.bvalid !== 1'b1 && n < 100);
    s_axi_req.bready <= 1'b0;
    guard(n);
    `CHK("bresp", r, s_axi_rsp.bresp)
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d, input logic [1:0] r);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_req.araddr  <= a;
    s_axi_req.arvalid <= 1'b1;
    s_axi_req.rready  <= 1'b1;
    do begin
      @(posedge aclk);
      n++;
      if (s_axi_rsp.arready) s_axi_req.arvalid <= 1'b0;
    end while (s_axi_rsp.rvalid !== 1'b1 && n < 100);
    s_axi_req.rready <= 1'b0;
    d = s_axi_rsp.rdata;
    guard(n);
    `CHK("rresp", r, s_axi_rsp.rresp)
  endtask

  // Pulse code 4 is sync, 2 is a verified frame, 1 is a failed frame.
  task automatic pulse(input logic [2:0] p);
    @(posedge aclk);
    {frame_info.sync_detect, frame_info.frame_verified, frame_info.frame_failed} <= p;
    @(posedge aclk);
    {frame_info.sync_detect, frame_info.frame_verified, frame_info.frame_failed} <= 3'h0;
    @(posedge aclk);
  endtask

  task automatic count_bits(input int n, output int cnt);
    cnt = 0;
    repeat (n) begin
      @(posedge aclk);
      if (master_req_bit === 1'b1) cnt++;
    end
  endtask

  task automatic count_rises(input int n, output int s, output int fr);
    logic ps;
    logic pf;
    s = 0;
    fr = 0;
    ps = sck;
    pf = fs_clk_out;
    repeat (n) begin
      @(posedge aclk);
      if (sck === 1'b1 && ps === 1'b0) s++;
      if (fs_clk_out === 1'b1 && pf === 1'b0) fr++;
      ps = sck;
      pf = fs_clk_out;
    end
  endtask

  // Counts sck rising edges within one half period of ws.
  task automatic ws_bits(output int b);
    logic w;
    logic s;
    int   n;
    b = 0;
    n = 0;
    w = ws;
    while (ws === w && n < 12000) begin
      @(posedge aclk);
      n++;
    end
    w = ws;
    s = sck;
    while (ws === w && n < 12000) begin
      @(posedge aclk);
      n++;
      if (sck === 1'b1 && s === 1'b0) b++;
      s = sck;
    end
    guard((n >= 12000) ? 100 : 0);
  endtask

  initial begin
    aresetn = 1'b0;
    s_axi_req = '0;
    frame_info = '0;
    stop_decoding = 1'b0;
    strap_fs_master = 1'b0;
    err_count = 0;
    samples_checked = 0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (6) @(posedge aclk);
    `CHK("fs_oe_n", 1'b1, fs_clk_out_oe_n)
    `CHK("req_active", 1'b1, master_req_active)
    rd(REG_CTRL, v, RESP_OKAY);
    `CHK("ctrl", 32'h0, v)
    rd(REG_STATUS, v, RESP_OKAY);
    `CHK("status", 8'hec, v[7:0])
    count_bits(6510, c);
    `CHK("bits_384", 1'b1, c >= 9 && c <= 11)
    $display("test reset done");
    wr(REG_CTRL, 32'h0000000c, RESP_OKAY);
    repeat (2) @(posedge aclk);
    `CHK("main_oe_n", 1'b1, main_clk_out_oe_n)
    `CHK("fs_oe_n", 1'b0, fs_clk_out_oe_n)
    // At 44.1 kHz over 8856 ns: 256fs gives about 100 rises, 64fs about 25.
    count_rises(2214, c, f);
    `CHK("sck_xtal", 1'b1, c >= 24 && c <= 26)
    `CHK("fs_out_256", 1'b1, f >= 99 && f <= 101)
    ws_bits(c);
    `CHK("ws_half", 32, c)
    wr(REG_CTRL, 32'h0, RESP_OKAY);
    wr(8'h08, 32'h0, RESP_SLVERR);
    rd(8'h08, v, RESP_SLVERR);
    $display("test outputs done");
    for (int i = 0; i < 4; i++) begin
      frame_info.crc_active  <= i[1];
      frame_info.free_format <= i[0];
      frame_info.rate_index  <= 4'h9;
      pulse(3'h4);
      for (int k = 0; k < need[i]; k++) begin
        `CHK("mute_verify", 1'b1, audio_mute)
        pulse(3'h2);
      end
      `CHK("mute_locked", 1'b0, audio_mute)
      `CHK("rate_locked", 4'h9, rate_index)
      stop_decoding <= 1'b1;
      repeat (8) @(posedge aclk);
      `CHK("stop_active", 1'b0, master_req_active)
      `CHK("stop_mute", 1'b1, audio_mute)
      stop_decoding <= 1'b0;
      repeat (8) @(posedge aclk);
      `CHK("resume_active", 1'b1, master_req_active)
    end
    count_bits(15625, c);
    `CHK("bits_160", 1'b1, c >= 9 && c <= 11)
    $display("test sync done");
    frame_info.crc_active  <= 1'b0;
    frame_info.free_format <= 1'b0;
    pulse(3'h4);
    pulse(3'h1);
    rd(REG_STATUS, v, RESP_OKAY);
    `CHK("fail_hunt", 3'h4, v[2:0])
    `CHK("src_xtal", 2'h2, v[11:10])
    wr(REG_CTRL, 32'h2, RESP_OKAY);
    repeat (4) @(posedge aclk);
    `CHK("slave_active", 1'b0, master_req_active)
    count_bits(2000, c);
    `CHK("slave_bits", 0, c)
    rd(REG_STATUS, v, RESP_OKAY);
    `CHK("src_slave", 2'h1, v[11:10])
    wr(REG_CTRL, 32'h0, RESP_OKAY);
    repeat (4) @(posedge aclk);
    `CHK("master_active", 1'b1, master_req_active)
    `CHK("master_rate", 4'h9, rate_index)
    $display("test port switch done");
    // Reset with fs-based master straps; the fs clock now stands for 384 x 29.4 kHz.
    aresetn <= 1'b0;
    strap_fs_master <= 1'b1;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    `CHK("rst2_mute", 1'b1, audio_mute)
    `CHK("rst2_rate", RATE_IDX_DEFAULT, rate_index)
    `CHK("rst2_oe_n", 2'h1, {main_clk_out_oe_n, fs_clk_out_oe_n})
    wr(REG_CTRL, 32'h00000008, RESP_OKAY);
    // 384 kbit/s scaled by 29.4/44.1 is 256 kbit/s, about 16 bits in 62.5 us.
    count_bits(15625, c);
    `CHK("bits_fs_256", 1'b1, c >= 15 && c <= 17)
    count_rises(2214, c, f);
    `CHK("sck_fs_384", 1'b1, c >= 16 && c <= 18)
    `CHK("fs_out_copy", 1'b1, f >= 99 && f <= 101)
    ws_bits(c);
    `CHK("ws_half_fs", 32, c)
    rd(REG_STATUS, v, RESP_OKAY);
    `CHK("src_fs", 2'h1, v[11:10])
    $display("test fs master done");
    end_of_test();
  end
endmodule

// ---- verilog/clk_sync_pkg.sv ----
package clk_sync_pkg;

  localparam longint unsigned CLK_HZ        = 250_000_000;
  localparam longint unsigned FS_ASSUMED_HZ = 44_100;
  localparam longint unsigned FS_RATIO_LO   = 256;
  localparam longint unsigned FS_RATIO_HI   = 384;
  localparam longint unsigned BITS_PER_KBIT = 1000;
  localparam int              NCO_W         = 32;

  localparam logic [7:0] REG_CTRL   = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;

  localparam int CTRL_PSEL    = 0;
  localparam int CTRL_MCK_DIS = 2;
  localparam int CTRL_FCK_EN  = 3;
  localparam int STAT_SYNC    = 0;
  localparam int STAT_MUTE    = 2;
  localparam int STAT_REQ     = 3;
  localparam int STAT_RATE    = 4;
  localparam int STAT_FS      = 8;
  localparam int STAT_SRC     = 10;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [1:0] PSEL_MASTER = 2'h0;

  localparam logic [3:0] RATE_IDX_DEFAULT = 4'he;
  localparam logic [3:0] RATE_IDX_FREE    = 4'h0;
  localparam logic [3:0] RATE_IDX_BAD     = 4'hf;
  localparam logic [8:0] KBPS [16] = '{9'h000, 9'h020, 9'h030, 9'h038, 9'h040, 9'h050,
    9'h060, 9'h070, 9'h080, 9'h0a0, 9'h0c0, 9'h0e0, 9'h100, 9'h140, 9'h180, 9'h000};

  localparam logic [1:0] FS_44K1 = 2'h0;
  localparam logic [1:0] FS_48K  = 2'h1;
  localparam logic [1:0] FS_32K  = 2'h2;

  localparam logic [3:0] SCK_HALF_256 = 4'h4;
  localparam logic [3:0] SCK_HALF_384 = 4'h6;
  localparam logic [3:0] SCK_HALF_512 = 4'h8;
  localparam logic [3:0] SCK_HALF_768 = 4'hc;
  localparam logic [1:0] FSO_HALF_256 = 2'h1;
  localparam logic [1:0] FSO_HALF_512 = 2'h2;
  localparam logic [1:0] FSO_HALF_768 = 2'h3;

  localparam logic [1:0] VERIFY_PLAIN_FREE  = 2'h2;
  localparam logic [1:0] VERIFY_PLAIN_FIXED = 2'h1;
  localparam logic [1:0] VERIFY_CRC_FREE    = 2'h1;
  localparam logic [1:0] VERIFY_CRC_FIXED   = 2'h0;

  typedef enum logic [1:0] {HUNT, VERIFY, LOCKED} sync_state_t;
  typedef enum logic [1:0] {SRC_MAIN, SRC_FS, SRC_XTAL} clk_src_t;

  typedef struct packed {
    logic [7:0]  awaddr;
    logic        awvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        wvalid;
    logic        bready;
    logic [7:0]  araddr;
    logic        arvalid;
    logic        rready;
  } axi_req_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } axi_rsp_t;

  typedef struct packed {
    logic       sync_detect;
    logic       frame_verified;
    logic       frame_failed;
    logic       crc_active;
    logic       free_format;
    logic [1:0] fs_index;
    logic [3:0] rate_index;
  } frame_info_t;

  function automatic logic [NCO_W-1:0] nco_inc(input longint unsigned kbps,
                                               input longint unsigned ref_hz);
    return NCO_W'(((kbps * BITS_PER_KBIT) << NCO_W) / ref_hz);
  endfunction

endpackage

// ---- verilog/decoder_clock_sync_bitrate_control.sv ----
`timescale 1ns/1ps
module decoder_clock_sync_bitrate_control
  import clk_sync_pkg::*;
(
  // Clock and reset.
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // Register bus.
  input  wire axi_req_t    s_axi_req,
  output axi_rsp_t         s_axi_rsp,
  // Clock pins and straps, all asynchronous.
  input  wire logic        main_clk_in,
  input  wire logic        fs_clk_in_a,
  input  wire logic        crystal_44k_clk_in,
  input  wire logic        fs_ratio_sel,
  input  wire logic        main_clk_rate_sel,
  input  wire logic        master_fs_source_sel,
  input  wire logic        stop_decoding,
  // Frame parser results.
  input  wire frame_info_t frame_info,
  // Generated clocks and buffered outputs.
  output logic             sck,
  output logic             ws,
  output logic             main_clk_out,
  output logic             main_clk_out_oe_n,
  output logic             fs_clk_out,
  output logic             fs_clk_out_oe_n,
  // Decoder and master request status.
  output logic             audio_mute,
  output logic             master_req_active,
  output logic             master_req_bit,
  output logic [3:0]       rate_index
);

  typedef struct packed {
    logic [2:0]  clk_s1;
    logic [2:0]  clk_s2;
    logic [2:0]  clk_prev;
    logic [3:0]  pin_s1;
    logic [3:0]  pin_s2;
    logic        aw_have;
    logic        w_have;
    logic [7:0]  awaddr;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [1:0]  rresp;
    logic [31:0] rdata;
    logic [1:0]  psel;
    logic        mck_dis;
    logic        fck_en;
    sync_state_t sst;
    logic [1:0]  vcnt;
    logic [3:0]  rate_idx;
    logic [1:0]  fs_idx;
    clk_src_t    src;
    logic [3:0]  sck_half;
    logic [1:0]  fso_half;
    logic [3:0]  ecnt;
    logic [1:0]  fcnt;
    logic        sck;
    logic [5:0]  bcnt;
    logic        fso;
    logic        fs_out;
    logic        main_out;
    logic        req_on;
    logic        req_bit;
    logic [NCO_W-1:0] acc;
  } st_t;

  st_t q_q;
  st_t q_d;

  logic             stop_s;
  logic             ratio_s;
  logic             rate_s;
  logic             fsm_s;
  logic             master;
  logic             m0;
  logic             wr_fire;
  logic             lose;
  logic             lock;
  logic [1:0]       need;
  logic [2:0]       edges;
  logic             src_edge;
  logic             tick;
  logic [NCO_W-1:0] inc;
  logic [NCO_W:0]   sum;
  clk_src_t         tgt_src;
  logic [3:0]       tgt_sck;
  logic [1:0]       tgt_fso;
  logic [31:0]      status;

  // Index 0 of each clock vector is main clock, 1 is fs clock, 2 is crystal clock.
  assign {fsm_s, rate_s, ratio_s, stop_s} = q_q.pin_s2;
  assign edges = q_q.clk_s2 ^ q_q.clk_prev;

  always_comb begin
    q_d = q_q;
    lock = 1'b0;
    inc = '0;
    sum = '0;
    src_edge = 1'b0;
    tgt_src = SRC_FS;
    tgt_sck = SCK_HALF_256;
    tgt_fso = FSO_HALF_512;
    status = '0;

    // Every asynchronous input passes two flops before use.
    q_d.clk_s1 = {crystal_44k_clk_in, fs_clk_in_a, main_clk_in};
    q_d.clk_s2 = q_q.clk_s1;
    q_d.clk_prev = q_q.clk_s2;
    q_d.pin_s1 = {master_fs_source_sel, main_clk_rate_sel, fs_ratio_sel, stop_decoding};
    q_d.pin_s2 = q_q.pin_s1;

    // Write channel: address and data are taken in either order.
    if (s_axi_req.awvalid && !q_q.aw_have && !q_q.bvalid) begin
      q_d.aw_have = 1'b1;
      q_d.awaddr = s_axi_req.awaddr;
    end
    if (s_axi_req.wvalid && !q_q.w_have && !q_q.bvalid) begin
      q_d.w_have = 1'b1;
      q_d.wdata = s_axi_req.wdata;
      q_d.wstrb = s_axi_req.wstrb;
    end
    wr_fire = q_q.aw_have && q_q.w_have;
    if (wr_fire) begin
      q_d.aw_have = 1'b0;
      q_d.w_have = 1'b0;
      q_d.bvalid = 1'b1;
      q_d.bresp = RESP_OKAY;
      if (q_q.awaddr == REG_CTRL) begin
        if (q_q.wstrb[0]) begin
          q_d.psel = q_q.wdata[CTRL_PSEL +: 2];
          q_d.mck_dis = q_q.wdata[CTRL_MCK_DIS];
          q_d.fck_en = q_q.wdata[CTRL_FCK_EN];
        end
      end else if (q_q.awaddr != REG_STATUS) begin
        q_d.bresp = RESP_SLVERR;
      end
    end
    if (q_q.bvalid && s_axi_req.bready) begin
      q_d.bvalid = 1'b0;
    end

    status[STAT_SYNC +: 2] = q_q.sst;
    status[STAT_MUTE] = (q_q.sst != LOCKED);
    status[STAT_REQ] = q_q.req_on;
    status[STAT_RATE +: 4] = q_q.rate_idx;
    status[STAT_FS +: 2] = q_q.fs_idx;
    status[STAT_SRC +: 2] = q_q.src;
    if (s_axi_req.arvalid && !q_q.rvalid) begin
      q_d.rvalid = 1'b1;
      q_d.rresp = RESP_OKAY;
      q_d.rdata = '0;
      if (s_axi_req.araddr == REG_CTRL) begin
        q_d.rdata[CTRL_PSEL +: 2] = q_q.psel;
        q_d.rdata[CTRL_MCK_DIS] = q_q.mck_dis;
        q_d.rdata[CTRL_FCK_EN] = q_q.fck_en;
      end else if (s_axi_req.araddr == REG_STATUS) begin
        q_d.rdata = status;
      end else begin
        q_d.rresp = RESP_SLVERR;
      end
    end else if (q_q.rvalid && s_axi_req.rready) begin
      q_d.rvalid = 1'b0;
    end

    // Port decode: 00 master; any other value (01 or 1x) is slave and makes no requests.
    master = (q_d.psel == PSEL_MASTER);
    m0 = master && !fsm_s;
    q_d.req_on = master && !stop_s;

    // Sync hunt and muted verification frames.
    if (frame_info.crc_active) begin
      need = frame_info.free_format ? VERIFY_CRC_FREE : VERIFY_CRC_FIXED;
    end else begin
      need = frame_info.free_format ? VERIFY_PLAIN_FREE : VERIFY_PLAIN_FIXED;
    end
    unique case (q_q.sst)
      HUNT: begin
        if (frame_info.sync_detect) begin
          if (need == VERIFY_CRC_FIXED) begin
            lock = 1'b1;
          end else begin
            q_d.sst = VERIFY;
            q_d.vcnt = need;
          end
        end
      end
      VERIFY: begin
        if (frame_info.frame_failed) begin
          q_d.sst = HUNT;
        end else if (frame_info.frame_verified) begin
          if (q_q.vcnt == VERIFY_PLAIN_FIXED) begin
            lock = 1'b1;
          end else begin
            q_d.vcnt = q_q.vcnt - VERIFY_PLAIN_FIXED;
          end
        end
      end
      LOCKED: begin
      end
    endcase
    lose = stop_s || (q_d.psel != q_q.psel);
    if (lose) begin
      q_d.sst = HUNT;
    end else if (lock) begin
      q_d.sst = LOCKED;
      if (master && frame_info.rate_index != q_q.rate_idx
          && frame_info.rate_index != RATE_IDX_FREE
          && frame_info.rate_index != RATE_IDX_BAD) begin
        q_d.rate_idx = frame_info.rate_index;
      end
      if (m0 && frame_info.fs_index != RATE_IDX_BAD[1:0]) begin
        q_d.fs_idx = frame_info.fs_index;
      end
    end

    // Target I2S source and division for the present mode.
    if (m0) begin
      if (q_q.fs_idx == FS_44K1) begin
        tgt_src = SRC_XTAL;
        tgt_sck = SCK_HALF_512;
        tgt_fso = FSO_HALF_512;
      end else if (q_q.fs_idx == FS_32K) begin
        tgt_src = SRC_MAIN;
        tgt_sck = rate_s ? SCK_HALF_768 : SCK_HALF_384;
        tgt_fso = rate_s ? FSO_HALF_768 : FSO_HALF_256;
      end else begin
        tgt_src = SRC_MAIN;
        tgt_sck = rate_s ? SCK_HALF_512 : SCK_HALF_256;
        tgt_fso = rate_s ? FSO_HALF_512 : FSO_HALF_256;
      end
    end else begin
      tgt_src = SRC_FS;
      tgt_sck = ratio_s ? SCK_HALF_384 : SCK_HALF_256;
    end

    unique case (q_q.src)
      SRC_MAIN: src_edge = edges[0];
      SRC_FS:   src_edge = edges[1];
      SRC_XTAL: src_edge = edges[2];
      default:  src_edge = 1'b0;
    endcase

    // Both edges of the source are counted, so a half count of N divides by N.
    if (src_edge) begin
      if (q_q.fcnt == q_q.fso_half - 2'h1) begin
        q_d.fcnt = '0;
        q_d.fso = !q_q.fso;
      end else begin
        q_d.fcnt = q_q.fcnt + 2'h1;
      end
      if (q_q.ecnt == q_q.sck_half - 4'h1) begin
        q_d.ecnt = '0;
        q_d.sck = !q_q.sck;
        if (q_q.sck) begin
          q_d.bcnt = q_q.bcnt + 6'h01;
          // A new source or ratio is taken only on an SCK falling edge.
          q_d.src = tgt_src;
          q_d.sck_half = tgt_sck;
          q_d.fso_half = tgt_fso;
          q_d.fcnt = '0;
        end
      end else begin
        q_d.ecnt = q_q.ecnt + 4'h1;
      end
    end
    q_d.fs_out = (q_d.src == SRC_FS) ? q_q.clk_s2[1] : q_d.fso;
    q_d.main_out = q_q.clk_s2[0];

    // Request bit pacing: a phase accumulator whose carry marks one bit.
    for (int i = 0; i < 16; i++) begin
      if (q_q.rate_idx == 4'(i)) begin
        if (fsm_s) begin
          inc = nco_inc(KBPS[i], FS_ASSUMED_HZ * (ratio_s ? FS_RATIO_HI : FS_RATIO_LO));
        end else begin
          inc = nco_inc(KBPS[i], CLK_HZ);
        end
      end
    end
    tick = fsm_s ? (q_q.clk_s2[1] && !q_q.clk_prev[1]) : 1'b1;
    q_d.req_bit = 1'b0;
    if (q_d.req_on && tick) begin
      sum = {1'b0, q_q.acc} + {1'b0, inc};
      q_d.acc = sum[NCO_W-1:0];
      q_d.req_bit = sum[NCO_W];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q_q <= '0;
      q_q.sst <= HUNT;
      q_q.rate_idx <= RATE_IDX_DEFAULT;
      q_q.fs_idx <= FS_44K1;
      q_q.src <= SRC_MAIN;
      q_q.sck_half <= SCK_HALF_512;
      q_q.fso_half <= FSO_HALF_512;
    end else begin
      q_q <= q_d;
    end
  end

  assign s_axi_rsp.awready = !q_q.aw_have && !q_q.bvalid;
  assign s_axi_rsp.wready = !q_q.w_have && !q_q.bvalid;
  assign s_axi_rsp.bvalid = q_q.bvalid;
  assign s_axi_rsp.bresp = q_q.bresp;
  assign s_axi_rsp.arready = !q_q.rvalid;
  assign s_axi_rsp.rvalid = q_q.rvalid;
  assign s_axi_rsp.rdata = q_q.rdata;
  assign s_axi_rsp.rresp = q_q.rresp;

  assign sck = q_q.sck;
  assign ws = q_q.bcnt[5];
  assign main_clk_out = q_q.main_out;
  assign main_clk_out_oe_n = q_q.mck_dis;
  assign fs_clk_out = q_q.fs_out;
  assign fs_clk_out_oe_n = !q_q.fck_en;
  assign audio_mute = (q_q.sst != LOCKED);
  assign master_req_active = q_q.req_on;
  assign master_req_bit = q_q.req_bit;
  assign rate_index = q_q.rate_idx;

endmodule
